// ===== tem_defines.vh
// Command codes, reset values and timing constants for the telemetry extrema block
`ifndef TEM_DEFINES_VH
`define TEM_DEFINES_VH
// Command codes
`define TEM_CMD_FINE_IOUT 8'hbb
`define TEM_CMD_SENSE_V 8'hfa
`define TEM_CMD_VIN_MAX 8'hde
`define TEM_CMD_VOUT_MAX 8'hdd
`define TEM_CMD_IOUT_MAX 8'hd7
`define TEM_CMD_TEMP_MAX 8'hdf
`define TEM_CMD_VIN_MIN 8'hfc
`define TEM_CMD_VOUT_MIN 8'hfb
`define TEM_CMD_IOUT_MIN 8'hd8
`define TEM_CMD_TEMP_MIN 8'hfd
`define TEM_CMD_LOG_STORE 8'hea
`define TEM_CMD_LOG_RESTORE 8'heb
`define TEM_CMD_LOG_CLEAR 8'hec
`define TEM_CMD_LOG_STATE 8'hed
`define TEM_CMD_LOG_READ 8'hee
// Reset values of the extrema
`define TEM_RST_MAX_L11 16'h7c00
`define TEM_RST_MAX_VOUT 16'hf800
`define TEM_RST_MIN_L11 16'h7bff
`define TEM_RST_MIN_VOUT 16'hffff
// Fine current readback clamp: 81.92 A / 2.5 mA = 32768 counts
`define TEM_FINE_MAX 16'h7fff
`define TEM_FINE_MIN 16'h8000
// Status bit positions
`define TEM_ST_EEPROM 0
`define TEM_ST_RAM 1
// Fast transfer limit
`define TEM_FAST_MS 24
`define TEM_CLK_KHZ 200000
`define TEM_FAST_CYC (`TEM_FAST_MS * `TEM_CLK_KHZ)
`endif

// ===== tem_host_model.sv
// Host side model that issues commands on the block's command port
`timescale 1ns/1ps
module tem_host_model (
  // Clock
  input wire clk,
  // Command request
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [1:0] cmd_page,
  output logic cmd_all_pages,
  // Command answer
  input wire cmd_ack,
  input wire cmd_nack,
  input wire [15:0] rd_data_q
);
  logic ack_seen, nack_seen;
  logic [15:0] data_seen;
  // Idle port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_page = 2'h0;
    cmd_all_pages = 1'b0;
  end
  // One command; the answer stands in the cycle after it is taken
  task automatic xfer(input logic w, input logic [7:0] code, input logic [1:0] page);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = code;
    cmd_page = page;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~code; // Released code no longer shows the command
    ack_seen = cmd_ack;
    nack_seen = cmd_nack;
    data_seen = rd_data_q;
  endtask
endmodule // tem_host_model

// ===== tem_monitor.sv
// Checker of the command answers and fault-log requests
`timescale 1ns/1ps
module tem_monitor #(
  parameter NCH = 4,
  parameter FAST_CYC = 10
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire cmd_ack,
  input wire cmd_nack,
  input wire [15:0] rd_data_q,
  input wire log_read_done,
  // Fault-log requests
  input wire log_store_q,
  input wire log_restore_q,
  input wire log_clear_q,
  input wire log_ram_frozen
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Request decode
  wire wr = cmd_valid && cmd_write;
  wire rd = cmd_valid && !cmd_write;
  wire ro = cmd_code inside {8'hbb, 8'hfa, 8'hde, 8'hdd, 8'hd7, 8'hdf,
    8'hfc, 8'hfb, 8'hd8, 8'hfd, 8'hed, 8'hee};
  AST_RO_NACK: assert property (wr && ro |=> cmd_nack && !cmd_ack)
    else $error("write to read-only code not refused");
  AST_STATUS_ACK: assert property (rd && cmd_code == 8'hed |=> cmd_ack && !cmd_nack)
    else $error("status read not answered");
  AST_STATUS_DATA: assert property (rd && cmd_code == 8'hed |=> rd_data_q[15:2] == 14'h0000
    && rd_data_q[1] == $past(log_ram_frozen))
    else $error("status word wrong");
  AST_RESTORE: assert property (wr && cmd_code == 8'heb |=> log_restore_q && log_ram_frozen)
    else $error("restore not started");
  AST_CLEAR: assert property (wr && cmd_code == 8'hec |=> log_clear_q)
    else $error("clear not started");
  AST_FROZEN_HOLD: assert property (log_ram_frozen && !log_read_done |=> log_ram_frozen)
    else $error("frozen buffer released early");
  AST_FROZEN_FREE: assert property (log_read_done && !(wr && cmd_code == 8'heb) |=> !log_ram_frozen)
    else $error("buffer not released after block read");
  AST_STORE_PULSE: assert property (log_store_q |=> !log_store_q)
    else $error("store request longer than one cycle");
  AST_ANSWER_CAUSE: assert property (cmd_ack || cmd_nack |-> $past(cmd_valid))
    else $error("answer without a command");
endmodule // tem_monitor
bind tem_telemetry_extrema tem_monitor #(.NCH(NCH), .FAST_CYC(FAST_CYC)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .rd_data_q(rd_data_q),
  .log_read_done(log_read_done), .log_store_q(log_store_q), .log_restore_q(log_restore_q),
  .log_clear_q(log_clear_q), .log_ram_frozen(log_ram_frozen));

// ===== tem_telemetry_extrema.v
// Telemetry readback, extrema tracking and fault-log command decode
//
// Function
// - Fine current readback is signed 16-bit, 2.5 mA per count.
// - Fine current readback clamps to plus or minus 81.92 A.
// - Sense voltage readback is an unsigned 16-bit magnitude.
// - Sense voltage comes from the latest current conversion, uncompensated.
// - Input voltage peak loads 0x7c00 on reset, any clear, any turn-on.
// - Output voltage peak loads 0xf800 on reset, page clear, turn-on.
// - Output current peak loads 0x7c00 on reset, page clear, turn-on.
// - Temperature peak loads 0x7c00 on reset, page clear, turn-on.
// - Input voltage minimum loads 0x7bff on reset, any clear, any turn-on.
// - Output voltage minimum loads 0xffff on reset, page clear, turn-on.
// - Output voltage minimum frozen while margined low ignoring faults.
// - Output current minimum loads 0x7bff on reset, page clear, turn-on.
// - Temperature minimum loads 0x7bff on reset, page clear, turn-on.
// - Command 0xea copies fault-log RAM into EEPROM.
// - Command 0xeb copies saved fault log back into RAM.
// - Command 0xec initialises log EEPROM and releases the transfer inhibit.
// - Status read at 0xed; fault log block read at 0xee.
// - Status bit 1 freezes log RAM until a complete block read.
// - Status bit 0 inhibits transfers; set after transfer, kept until clear.
// - Latch-off or store starts transfer; fast within 24 ms, else after refresh.
`timescale 1ns/1ps
`include "tem_defines.vh"

module tem_telemetry_extrema #(
  parameter NCH = 4,
  parameter FAST_CYC = `TEM_FAST_CYC
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Command port from the PMBus engine
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [1:0] cmd_page,
  input wire cmd_all_pages,
  output reg cmd_ack,
  output reg cmd_nack,
  output reg [15:0] rd_data_q,
  input wire log_read_done,
  // Conversion results
  input wire vin_valid,
  input wire [15:0] vin_value,
  input wire meas_valid,
  input wire [1:0] meas_chan,
  input wire [15:0] vout_value,
  input wire [15:0] iout_value,
  input wire [15:0] temp_value,
  input wire signed [31:0] iout_ma_x10,
  input wire [15:0] current_sense_mag,
  input wire all_refreshed,
  // Channel state
  input wire [NCH-1:0] chan_on,
  input wire [NCH-1:0] margin_low_ignore,
  input wire [NCH-1:0] latch_off_fault,
  // Fault-log configuration and persisted status
  input wire log_enable,
  input wire fast_log,
  input wire eeprom_flag_stored,
  // Fault-log engine requests
  output reg log_store_q,
  output reg log_restore_q,
  output reg log_clear_q,
  output wire log_ram_frozen
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [15:0] input_voltage_maximum_q;
  reg [15:0] input_voltage_minimum_q;
  reg [16*NCH-1:0] output_voltage_maximum_q;
  reg [16*NCH-1:0] output_voltage_minimum_q;
  reg [16*NCH-1:0] iout_max_q;
  reg [16*NCH-1:0] iout_min_q;
  reg [16*NCH-1:0] temp_max_q;
  reg [16*NCH-1:0] temp_min_q;
  reg [16*NCH-1:0] fine_iout_q;
  reg [16*NCH-1:0] sense_q;
  reg [NCH-1:0] chan_on_q;
  reg [NCH-1:0] fault_q;
  reg st_eeprom_q;
  reg st_ram_q;
  reg st_loaded_q;
  reg pend_q;
  reg [31:0] wait_q;
  integer i;

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // Command port
  //   One command may be taken on every rising edge with cmd_valid high.
  //   The answer, ack or nack, stands for exactly one cycle after that.
  //   A read leaves its word in rd_data_q until the next read replaces it.
  //   Writes to readback, extrema, status and log block read codes are refused.
  //   The log block bytes themselves come from the engine, not from here.
  // Extrema
  //   Each conversion pulse compares its value against the stored pair.
  //   The compare is unsigned on the encoded word, as the host reads it.
  //   Reset, clear-faults and a channel turn-on load the start values.
  //   A reload wins over an update that falls into the same cycle.
  //   Input voltage extrema are shared, so any turn-on reloads them.
  //   Clear-faults to any page reloads the shared input voltage pair.
  //   Per-channel extrema reload only for the addressed page or all pages.
  //   Margin low with faults ignored stops the output voltage minimum only.
  // Fine current readback
  //   The input is signed tenths of a milliamp; one count is 2.5 mA.
  //   The quotient truncates toward zero and saturates at the word limits.
  //   Hosts with larger currents must use the standard readback instead.
  // Sense voltage readback
  //   The raw magnitude is latched with the current conversion of a channel.
  //   No temperature correction is applied on this path.
  // Fault-log status
  //   Bit 1 marks a restored buffer, frozen until a complete block read.
  //   A restore and a completed read in one cycle leave the buffer frozen.
  //   Bit 0 inhibits further transfers once one has been made.
  //   Bit 0 is persisted outside; its stored copy is taken once after reset.
  //   Only the clear command releases the inhibit again.
  //   A transfer firing in the same cycle as a clear keeps the inhibit set.
  // Transfer scheduling
  //   A store command or a new latch-off fault arms one pending transfer.
  //   Triggers are ignored while pending, inhibited or with logging off.
  //   In fast mode the transfer fires after FAST_CYC cycles of waiting.
  //   In slow mode it fires once all channels report refreshed readings.
  //   The store request is a one-cycle pulse to the fault-log engine.
  // Hazards
  //   The latch-off input is edge detected; a held fault triggers once.
  //   The turn-on detector starts from all channels off after reset.
  //   A channel already on at reset release therefore reloads its extrema.
  //   The wait counter is wide enough for the full fast-mode delay.

  assign log_ram_frozen = st_ram_q;

  // Command classification
  wire is_clear_faults = cmd_valid && cmd_write && (cmd_code == 8'h03);
  wire is_store = cmd_valid && cmd_write && (cmd_code == `TEM_CMD_LOG_STORE);
  wire is_restore = cmd_valid && cmd_write && (cmd_code == `TEM_CMD_LOG_RESTORE);
  wire is_clear_log = cmd_valid && cmd_write && (cmd_code == `TEM_CMD_LOG_CLEAR);
  wire [NCH-1:0] turn_on = chan_on & ~chan_on_q;
  wire [NCH-1:0] new_fault = latch_off_fault & ~fault_q;
  // Pending transfer fires this cycle
  wire xfer_fire = pend_q && ((fast_log && (wait_q >= FAST_CYC - 1)) || (!fast_log && all_refreshed));

  // Read-only codes, where a write is refused
  reg ro_code;
  always @* begin
    case (cmd_code)
      `TEM_CMD_FINE_IOUT, `TEM_CMD_SENSE_V, `TEM_CMD_VIN_MAX, `TEM_CMD_VOUT_MAX,
      `TEM_CMD_IOUT_MAX, `TEM_CMD_TEMP_MAX, `TEM_CMD_VIN_MIN, `TEM_CMD_VOUT_MIN,
      `TEM_CMD_IOUT_MIN, `TEM_CMD_TEMP_MIN, `TEM_CMD_LOG_STATE,
      `TEM_CMD_LOG_READ: ro_code = 1'b1;
      default: ro_code = 1'b0;
    endcase
  end

  // Fine current clamp, 2.5 mA per count
  function [15:0] clamp_fine;
    input signed [31:0] ma_x10;
    reg signed [31:0] cnt;
    begin
      cnt = ma_x10 / 25;
      if (cnt > 32'sd32767) clamp_fine = `TEM_FINE_MAX;
      else if (cnt < -32'sd32768) clamp_fine = `TEM_FINE_MIN;
      else clamp_fine = cnt[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Readback answer and refusal
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      cmd_ack <= cmd_valid && !(cmd_write && ro_code);
      cmd_nack <= cmd_valid && cmd_write && ro_code;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `TEM_CMD_FINE_IOUT: rd_data_q <= fine_iout_q[16*cmd_page +: 16];
          `TEM_CMD_SENSE_V: rd_data_q <= sense_q[16*cmd_page +: 16];
          `TEM_CMD_VIN_MAX: rd_data_q <= input_voltage_maximum_q;
          `TEM_CMD_VIN_MIN: rd_data_q <= input_voltage_minimum_q;
          `TEM_CMD_VOUT_MAX: rd_data_q <= output_voltage_maximum_q[16*cmd_page +: 16];
          `TEM_CMD_VOUT_MIN: rd_data_q <= output_voltage_minimum_q[16*cmd_page +: 16];
          `TEM_CMD_IOUT_MAX: rd_data_q <= iout_max_q[16*cmd_page +: 16];
          `TEM_CMD_IOUT_MIN: rd_data_q <= iout_min_q[16*cmd_page +: 16];
          `TEM_CMD_TEMP_MAX: rd_data_q <= temp_max_q[16*cmd_page +: 16];
          `TEM_CMD_TEMP_MIN: rd_data_q <= temp_min_q[16*cmd_page +: 16];
          `TEM_CMD_LOG_STATE: rd_data_q <= {14'h0000, st_ram_q, st_eeprom_q};
          default: rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Extrema tracking
  // ----------------------------------------------------------------
  // Input voltage extrema, shared by all channels
  always @(posedge clk) begin
    if (sys_rst || is_clear_faults || (|turn_on)) begin
      input_voltage_maximum_q <= `TEM_RST_MAX_L11;
      input_voltage_minimum_q <= `TEM_RST_MIN_L11;
    end else if (vin_valid) begin
      if (vin_value > input_voltage_maximum_q) input_voltage_maximum_q <= vin_value;
      if (vin_value < input_voltage_minimum_q) input_voltage_minimum_q <= vin_value;
    end
  end

  // Per-channel extrema and readbacks
  always @(posedge clk) begin
    if (sys_rst) begin
      chan_on_q <= {NCH{1'b0}};
      fine_iout_q <= {16*NCH{1'b0}};
      sense_q <= {16*NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        output_voltage_maximum_q[16*i +: 16] <= `TEM_RST_MAX_VOUT;
        output_voltage_minimum_q[16*i +: 16] <= `TEM_RST_MIN_VOUT;
        iout_max_q[16*i +: 16] <= `TEM_RST_MAX_L11;
        iout_min_q[16*i +: 16] <= `TEM_RST_MIN_L11;
        temp_max_q[16*i +: 16] <= `TEM_RST_MAX_L11;
        temp_min_q[16*i +: 16] <= `TEM_RST_MIN_L11;
      end
    end else begin
      chan_on_q <= chan_on;
      for (i = 0; i < NCH; i = i + 1) begin
        if (turn_on[i] || (is_clear_faults && (cmd_all_pages || cmd_page == i))) begin
          output_voltage_maximum_q[16*i +: 16] <= `TEM_RST_MAX_VOUT;
          output_voltage_minimum_q[16*i +: 16] <= `TEM_RST_MIN_VOUT;
          iout_max_q[16*i +: 16] <= `TEM_RST_MAX_L11;
          iout_min_q[16*i +: 16] <= `TEM_RST_MIN_L11;
          temp_max_q[16*i +: 16] <= `TEM_RST_MAX_L11;
          temp_min_q[16*i +: 16] <= `TEM_RST_MIN_L11;
        end else if (meas_valid && meas_chan == i) begin
          if (vout_value > output_voltage_maximum_q[16*i +: 16])
            output_voltage_maximum_q[16*i +: 16] <= vout_value;
          if (!margin_low_ignore[i] && vout_value < output_voltage_minimum_q[16*i +: 16])
            output_voltage_minimum_q[16*i +: 16] <= vout_value;
          if (iout_value > iout_max_q[16*i +: 16]) iout_max_q[16*i +: 16] <= iout_value;
          if (iout_value < iout_min_q[16*i +: 16]) iout_min_q[16*i +: 16] <= iout_value;
          if (temp_value > temp_max_q[16*i +: 16]) temp_max_q[16*i +: 16] <= temp_value;
          if (temp_value < temp_min_q[16*i +: 16]) temp_min_q[16*i +: 16] <= temp_value;
        end
        if (meas_valid && meas_chan == i) begin
          fine_iout_q[16*i +: 16] <= clamp_fine(iout_ma_x10);
          sense_q[16*i +: 16] <= current_sense_mag;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault-log command group
  // ----------------------------------------------------------------
  // Status bits, transfer scheduling and engine requests
  always @(posedge clk) begin
    if (sys_rst) begin
      st_ram_q <= 1'b0;
      st_eeprom_q <= 1'b0;
      st_loaded_q <= 1'b0;
      fault_q <= {NCH{1'b0}};
      pend_q <= 1'b0;
      wait_q <= 32'h0000_0000;
      log_store_q <= 1'b0;
      log_restore_q <= 1'b0;
      log_clear_q <= 1'b0;
    end else begin
      fault_q <= latch_off_fault;
      log_store_q <= 1'b0;
      log_restore_q <= is_restore;
      log_clear_q <= is_clear_log;
      // Persisted inhibit is picked up once after reset
      if (!st_loaded_q) begin
        st_loaded_q <= 1'b1;
        st_eeprom_q <= eeprom_flag_stored;
      end
      // Restore locks the RAM; a complete block read frees it; restore wins
      if (is_restore) st_ram_q <= 1'b1;
      else if (log_read_done) st_ram_q <= 1'b0;
      // Start a transfer on store or a new latch-off
      if (!pend_q && log_enable && !st_eeprom_q && (is_store || (|new_fault))) begin
        pend_q <= 1'b1;
        wait_q <= 32'h0000_0000;
      end else if (pend_q) begin
        wait_q <= wait_q + 32'h0000_0001;
        if (xfer_fire) begin
          pend_q <= 1'b0;
          log_store_q <= 1'b1;
          st_eeprom_q <= 1'b1;
        end
      end
      // Clear releases the inhibit unless a transfer fires this cycle
      if (is_clear_log && !xfer_fire) st_eeprom_q <= 1'b0;
    end
  end

endmodule // tem_telemetry_extrema

// ===== tem_telemetry_extrema_bench.sv
// Self-checking testbench of the telemetry extrema block
`timescale 1ns/1ps
module tem_telemetry_extrema_bench;
  localparam int FAST = 10;
  logic clk, sys_rst, log_read_done, vin_valid, meas_valid, log_enable;
  logic cmd_valid, cmd_write, cmd_all_pages, cmd_ack, cmd_nack;
  logic log_store_q, log_restore_q, log_clear_q, log_ram_frozen;
  logic [1:0] meas_chan, cmd_page;
  logic [7:0] cmd_code;
  logic [3:0] chan_on, margin_low_ignore, latch_off_fault;
  logic all_refreshed, fast_log;
  logic [15:0] rd_data_q, vin_value, vout_value, iout_value, temp_value, current_sense_mag;
  logic signed [31:0] iout_ma_x10;
  int n_errors = 0, n_compared = 0, seed = 55547, i, k;
  int corner [4] = '{819200, 819175, -819225, -24};
  logic [15:0] mx [4], mn [4], v [4];
  logic [7:0] cmx [4] = '{8'hde, 8'hdd, 8'hd7, 8'hdf};
  logic [7:0] cmn [4] = '{8'hfc, 8'hfb, 8'hd8, 8'hfd};
  logic [15:0] rmx [4] = '{16'h7c00, 16'hf800, 16'h7c00, 16'h7c00};
  logic [15:0] rmn [4] = '{16'h7bff, 16'hffff, 16'h7bff, 16'h7bff};
  tem_host_model host (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_all_pages,
    .cmd_ack, .cmd_nack, .rd_data_q);
  tem_telemetry_extrema #(.FAST_CYC(FAST)) dut (.clk, .sys_rst, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_page, .cmd_all_pages, .cmd_ack, .cmd_nack, .rd_data_q, .log_read_done,
    .vin_valid, .vin_value, .meas_valid, .meas_chan, .vout_value, .iout_value, .temp_value,
    .iout_ma_x10, .current_sense_mag, .all_refreshed, .chan_on, .margin_low_ignore,
    .latch_off_fault, .log_enable, .fast_log, .eeprom_flag_stored(1'b0),
    .log_store_q, .log_restore_q, .log_clear_q, .log_ram_frozen);
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Fine readback: tenths of a milliamp over 25, toward zero, saturated
  function automatic logic [15:0] fine(input int ma);
    int q;
    q = ma / 25;
    if (q > 32767) q = 32767;
    if (q < -32768) q = -32768;
    return q[15:0];
  endfunction
  task automatic rd(input logic [7:0] code, input logic [1:0] page, input logic [15:0] exp);
    host.xfer(1'b0, code, page);
    check(host.data_seen, exp);
  endtask
  // One conversion result; the expected extrema follow channel 0
  task automatic meas(input logic [1:0] ch);
    @(negedge clk);
    vin_valid = 1'b1;
    meas_valid = 1'b1;
    meas_chan = ch;
    {vin_value, vout_value, iout_value, temp_value} = {v[0], v[1], v[2], v[3]};
    @(negedge clk);
    vin_valid = 1'b0;
    meas_valid = 1'b0;
    for (int j = 0; j < 4; j++) begin
      if (v[j] > mx[j]) mx[j] = v[j];
      if (v[j] < mn[j] && !(j == 1 && margin_low_ignore[0])) mn[j] = v[j];
    end
  endtask
  task automatic chk_ext(input bit rst);
    for (int j = 0; j < 4; j++) begin
      if (rst) mx[j] = rmx[j];
      if (rst) mn[j] = rmn[j];
      rd(cmx[j], 2'd0, mx[j]);
      rd(cmn[j], 2'd0, mn[j]);
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  // Main sequence
  initial begin
    {sys_rst, log_enable, fast_log, all_refreshed} = 4'b1111;
    latch_off_fault = 4'h0;
    {log_read_done, vin_valid, meas_valid, meas_chan, chan_on, margin_low_ignore} = '0;
    {vin_value, vout_value, iout_value, temp_value, current_sense_mag, iout_ma_x10} = '0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk_ext(1'b1);
    chan_on = 4'h1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 24; i++) begin
      for (k = 0; k < 4; k++) v[k] = $random(seed);
      if (i == 16) margin_low_ignore = 4'h1;
      if (i == 16) v[1] = 16'h0000;
      meas(2'd0);
      if (i == 15 || i == 16) chk_ext(1'b0);
    end
    margin_low_ignore = 4'h0;
    host.xfer(1'b1, 8'h03, 2'd0);
    chk_ext(1'b1);
    meas(2'd0);
    chan_on = 4'h0;
    repeat (2) @(negedge clk);
    chan_on = 4'h1;
    repeat (3) @(negedge clk);
    chk_ext(1'b1);
    for (i = 0; i < 12; i++) begin
      iout_ma_x10 = (i < 4) ? corner[i] : $random(seed) % 1000000;
      current_sense_mag = $random(seed);
      meas(2'd2);
      rd(8'hbb, 2'd2, fine(iout_ma_x10));
      rd(8'hfa, 2'd2, current_sense_mag);
    end
    for (i = 0; i < 4; i++) begin
      host.xfer(1'b1, cmx[i], 2'd0);
      check({15'h0, host.nack_seen}, 16'h1);
      host.xfer(1'b1, cmn[i], 2'd0);
      check({15'h0, host.nack_seen}, 16'h1);
    end
    rd(8'hed, 2'd0, 16'h0000);
    host.xfer(1'b1, 8'hea, 2'd0);
    for (k = 0; k < 40 && log_store_q !== 1'b1; k++) @(negedge clk);
    check(16'(k), 16'(FAST));
    rd(8'hed, 2'd0, 16'h0001);
    host.xfer(1'b1, 8'hea, 2'd0);
    k = 0;
    repeat (FAST + 4) begin
      @(negedge clk);
      k += log_store_q;
    end
    check(16'(k), 16'h0);
    host.xfer(1'b1, 8'heb, 2'd0);
    rd(8'hed, 2'd0, 16'h0003);
    log_read_done = 1'b1;
    @(negedge clk);
    log_read_done = 1'b0;
    rd(8'hed, 2'd0, 16'h0001);
    host.xfer(1'b1, 8'hec, 2'd0);
    rd(8'hed, 2'd0, 16'h0000);
    // Slow mode: a latch-off waits for refreshed readings
    fast_log = 1'b0;
    all_refreshed = 1'b0;
    @(negedge clk);
    latch_off_fault = 4'h4;
    k = 0;
    repeat (FAST + 4) begin
      @(negedge clk);
      k += log_store_q;
    end
    check(16'(k), 16'h0);
    all_refreshed = 1'b1;
    @(negedge clk);
    check({15'h0, log_store_q}, 16'h1);
    rd(8'hed, 2'd0, 16'h0001);
    print_verdict;
  end
endmodule // tem_telemetry_extrema_bench
